//--- rtl/adrd_cfg.svh
// Purpose: constants of the ADC redundancy and diagnostics block
// Assumes: 200 MHz hclk, AHB-Lite register access
// Notes: times are in microseconds; cycle counts are derived in the module
//
// Functional notes
// - status conversion stores analog supply and digital supply words, 100 uV/code
// - redundant status conversion takes the same time as plain status conversion
// - three per-channel integrate/differentiate filters plus one redundant filter
// - redundancy available on every conversion command except plain aux and plain status
// - redundant conversion feeds one bit stream to both filters, compare at end
// - any mismatch stores fault code 0xFF0X instead of the result
// - valid results stay within 0x0000 to 0xDFFF
// - fault code bits 3..0 flag mismatching nibbles 15:12 down to 3:0
// - fault code low nibble is never all zero
// - one channel under redundancy at a time; select 00 picks it automatically
// - select 01/10/11 picks ADC1/2/3; 00 covers cells 1,7,13,4,10
// - aux, reference, sum, temperature, supplies on ADC1; redundancy only with 00/01
// - force-fail bit makes every later redundant comparison mismatch
// - combined conversion measures fifteen cells and the stack sum
// - overlap: cell 7 on ADC1+ADC2, then cell 13 on ADC2+ADC3
// - overlap results go to cell 7, 8, 13 and 14 slots
// - overlap total time 384 us fastest to 67,119 us slowest
// - combined total time 1,147 us fastest to 201,351 us slowest
// - auxiliary conversion measures second reference on ADC1, stored in aux group
// - mux check steps all channels, sets fail flag on any fault else clears
// - mux fail flag set at reset and by clear status command
// - mux check about 400 us with reference up, 4.5 ms in standby
`ifndef ADRD_CFG_SVH
`define ADRD_CFG_SVH

`define ADRD_CLK_MHZ 200
`define ADRD_OFS_CTRL 8'h00
`define ADRD_OFS_CMD 8'h04
`define ADRD_OFS_STATUS 8'h08
`define ADRD_OFS_RES 8'h40
`define ADRD_NUM_RES 20
`define ADRD_CTRL_MODE_LSB 0
`define ADRD_CTRL_PS_LSB 3
`define ADRD_CTRL_FF_BIT 5
`define ADRD_STS_BUSY_BIT 0
`define ADRD_STS_MUXF_BIT 1
`define ADRD_OP_STAT 4'h1
`define ADRD_OP_STATD 4'h2
`define ADRD_OP_AUX 4'h3
`define ADRD_OP_AUXD 4'h4
`define ADRD_OP_VSC 4'h5
`define ADRD_OP_OL 4'h6
`define ADRD_OP_MUX 4'h7
`define ADRD_OP_CLR 4'h8
`define ADRD_IDX_SUM 5'h0F
`define ADRD_IDX_REF 5'h13
`define ADRD_RES_RST 16'hFFFF
`define ADRD_RES_MAX 16'hDFFF
`define ADRD_FAULT_HI 12'hFF0
`define ADRD_T_STAT_US '{742, 858, 1556, 2022, 2953, 4814, 8538, 134211}
`define ADRD_T_AUX_US '{1825, 2116, 3862, 5025, 7353, 12007, 21316, 335498}
`define ADRD_T_VSC_US '{1147, 1322, 2369, 3067, 4463, 7256, 12842, 201351}
`define ADRD_T_OL_US '{384, 442, 791, 1024, 1490, 2420, 4282, 67119}
`define ADRD_T_MUX_UP_US 400
`define ADRD_T_MUX_SB_US 4500

`endif

//--- rtl/adrd_pkg.sv
// Purpose: types of the ADC redundancy and diagnostics block
// Assumes: nothing
// Notes: constants live in adrd_cfg.svh
package adrd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_MUX} adrd_state_e;
  typedef enum logic [3:0] {C_NONE, C_STAT, C_STATD, C_AUX, C_AUXD, C_VSC, C_OL, C_MUX,
    C_CLR} adrd_cmd_e;
endpackage

//--- rtl/adrd_diag.sv
// Purpose: conversion sequencing, redundant filter check and mux check with AHB-Lite access
// Assumes: modulator bits synchronous to hclk, one bit per cycle per channel
// Notes: commands written while busy are dropped
`timescale 1ns/10ps
`default_nettype none
`include "adrd_cfg.svh"

module adrd_diag #(
  parameter int unsigned TIME_DIV = 1,
  parameter int unsigned T_STAT_US [8] = `ADRD_T_STAT_US,
  parameter int unsigned T_AUX_US [8] = `ADRD_T_AUX_US,
  parameter int unsigned T_VSC_US [8] = `ADRD_T_VSC_US,
  parameter int unsigned T_OL_US [8] = `ADRD_T_OL_US,
  parameter int unsigned T_MUX_UP_US = `ADRD_T_MUX_UP_US,
  parameter int unsigned T_MUX_SB_US = `ADRD_T_MUX_SB_US
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] mod_bit,
  input wire logic reference_powered_state,
  input wire logic mux_channel_fault,
  output logic busy
);

  function automatic logic [31:0] us2cyc(input int unsigned us);
    longint unsigned c;
    c = (longint'(us) * `ADRD_CLK_MHZ) / TIME_DIV;
    if (c == 0) begin
      c = 1;
    end
    return c[31:0];
  endfunction

  // bus side
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [2:0] mode;
  logic [1:0] redundancy_path_select;
  logic force_redundancy_fail;
  logic mux_fail_flag;
  logic [15:0] res [`ADRD_NUM_RES];

  // sequencer
  adrd_pkg::adrd_state_e state;
  adrd_pkg::adrd_state_e next_state;
  adrd_pkg::adrd_cmd_e cmd;
  adrd_pkg::adrd_cmd_e op;
  logic [31:0] tot_cnt;
  logic [31:0] step_cnt;
  logic [2:0] step_idx;
  logic mux_acc;

  wire a_valid = hsel & htrans[1] & hready;
  wire [7:0] a_ofs = haddr[7:0];
  // index kept at six bits so offsets past the last result do not alias onto low slots
  wire [5:0] a_ridx6 = a_ofs[7:2] - 6'h10;
  wire [4:0] a_ridx = a_ridx6[4:0];
  wire a_is_res = (a_ofs >= `ADRD_OFS_RES) && (a_ridx6 < 6'(`ADRD_NUM_RES));
  wire cmd_wr = wr_pend && (wr_addr == `ADRD_OFS_CMD) && (state == adrd_pkg::ST_IDLE);
  wire ctrl_wr = wr_pend && (wr_addr == `ADRD_OFS_CTRL);

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (a_ofs == `ADRD_OFS_CTRL) begin
      rd_val = 32'({force_redundancy_fail, redundancy_path_select, mode});
    end else if (a_ofs == `ADRD_OFS_STATUS) begin
      rd_val = 32'({mux_fail_flag, busy});
    end else if (a_is_res) begin
      rd_val = {16'h0000, res[a_ridx]};
    end
  end

  always_comb begin
    op = adrd_pkg::C_NONE;
    if (cmd_wr) begin
      case (hwdata[3:0])
        `ADRD_OP_STAT: op = adrd_pkg::C_STAT;
        `ADRD_OP_STATD: op = adrd_pkg::C_STATD;
        `ADRD_OP_AUX: op = adrd_pkg::C_AUX;
        `ADRD_OP_AUXD: op = adrd_pkg::C_AUXD;
        `ADRD_OP_VSC: op = adrd_pkg::C_VSC;
        `ADRD_OP_OL: op = adrd_pkg::C_OL;
        `ADRD_OP_MUX: op = adrd_pkg::C_MUX;
        `ADRD_OP_CLR: op = adrd_pkg::C_CLR;
        default: op = adrd_pkg::C_NONE;
      endcase
    end
  end

  // step count and total length per command; status plain and redundant share a table
  logic [2:0] nsteps;
  logic [31:0] tot_len;
  always_comb begin
    case (cmd)
      adrd_pkg::C_STAT, adrd_pkg::C_STATD: begin
        nsteps = 3'd4;
        tot_len = us2cyc(T_STAT_US[mode]);
      end
      adrd_pkg::C_AUX, adrd_pkg::C_AUXD: begin
        nsteps = 3'd1;
        tot_len = us2cyc(T_AUX_US[mode]);
      end
      adrd_pkg::C_VSC: begin
        nsteps = 3'd6;
        tot_len = us2cyc(T_VSC_US[mode]);
      end
      adrd_pkg::C_OL: begin
        nsteps = 3'd2;
        tot_len = us2cyc(T_OL_US[mode]);
      end
      default: begin
        nsteps = 3'd0;
        tot_len = reference_powered_state ? us2cyc(T_MUX_UP_US) : us2cyc(T_MUX_SB_US);
      end
    endcase
  end

  // measurement slots; the remainder after the last slot stands for calibration
  wire [31:0] step_raw = tot_len / 32'(nsteps + 3'd1);
  wire [31:0] step_len = (step_raw == 0) ? 32'd1 : step_raw;
  wire step_end = (state == adrd_pkg::ST_CONV) && (step_idx < nsteps) &&
    (step_cnt == step_len - 32'd1);
  wire run_end = (state != adrd_pkg::ST_IDLE) && (tot_cnt == tot_len - 32'd1);

  // result slot per channel for the current step
  logic [2:0] wen;
  logic [4:0] widx [3];
  logic red_en;
  logic [1:0] red_ch;
  wire ps_low = (redundancy_path_select[1] == 1'b0);
  always_comb begin
    wen = 3'b000;
    widx[0] = 5'd0;
    widx[1] = 5'd0;
    widx[2] = 5'd0;
    red_en = 1'b0;
    red_ch = 2'd0;
    case (cmd)
      adrd_pkg::C_STAT, adrd_pkg::C_STATD: begin
        wen = 3'b001;
        widx[0] = 5'(`ADRD_IDX_SUM + 5'(step_idx));
        red_en = (cmd == adrd_pkg::C_STATD) && ps_low;
      end
      adrd_pkg::C_AUX, adrd_pkg::C_AUXD: begin
        wen = 3'b001;
        widx[0] = `ADRD_IDX_REF;
        red_en = (cmd == adrd_pkg::C_AUXD) && ps_low;
      end
      adrd_pkg::C_VSC: begin
        if (step_idx < 3'd5) begin
          wen = 3'b111;
          widx[0] = 5'(step_idx);
          widx[1] = 5'(step_idx) + 5'd5;
          widx[2] = 5'(step_idx) + 5'd10;
          red_en = 1'b1;
          // automatic pick rotates so cells 1,7,13,4,10 get covered
          if (redundancy_path_select == 2'b00) begin
            red_ch = (step_idx == 3'd1 || step_idx == 3'd4) ? 2'd1 :
              (step_idx == 3'd2) ? 2'd2 : 2'd0;
          end else begin
            red_ch = redundancy_path_select - 2'd1;
          end
        end else begin
          wen = 3'b001;
          widx[0] = `ADRD_IDX_SUM;
          red_en = ps_low;
        end
      end
      adrd_pkg::C_OL: begin
        if (step_idx == 3'd0) begin
          wen = 3'b011;
          widx[0] = 5'd7;
          widx[1] = 5'd6;
          red_en = (redundancy_path_select != 2'b11);
          red_ch = (redundancy_path_select == 2'b01) ? 2'd0 : 2'd1;
        end else begin
          wen = 3'b110;
          widx[1] = 5'd13;
          widx[2] = 5'd12;
          red_en = (redundancy_path_select != 2'b01);
          red_ch = (redundancy_path_select == 2'b11) ? 2'd2 : 2'd1;
        end
      end
      default: begin
        wen = 3'b000;
      end
    endcase
  end

  // four identical integrate/differentiate machines; index 3 is the redundant one
  wire [3:0] fbit = {mod_bit[red_ch] & red_en, mod_bit};
  // boundary samples dropped: the redundant path select changes there and would mix channels
  wire filt_run = (state == adrd_pkg::ST_CONV) && !step_end;
  logic [15:0] fres [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      logic [31:0] acc;
      logic [31:0] base;
      wire [31:0] diff = acc - base;
      assign fres[g] = (diff > 32'(`ADRD_RES_MAX)) ? `ADRD_RES_MAX : diff[15:0];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          acc <= 32'h0000_0000;
          base <= 32'h0000_0000;
        end else begin
          acc <= acc + 32'(fbit[g] & filt_run);
          base <= (step_end || state == adrd_pkg::ST_IDLE) ? acc : base;
        end
      end
    end
  endgenerate

  // per-word compare; forcing flips bit 0 so nibble 0 always reports
  wire [15:0] red_cmp = fres[3] ^ {15'h0000, force_redundancy_fail};
  wire [15:0] xdiff = fres[red_ch] ^ red_cmp;
  wire [3:0] nib = {|xdiff[15:12], |xdiff[11:8], |xdiff[7:4], |xdiff[3:0]};
  wire red_fail = red_en && (nib != 4'h0);
  logic [15:0] wval [3];
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      wval[k] = (red_fail && red_ch == 2'(k)) ? {`ADRD_FAULT_HI, nib} : fres[k];
    end
  end

  always_comb begin
    next_state = state;
    if (state == adrd_pkg::ST_IDLE) begin
      if (op == adrd_pkg::C_MUX) begin
        next_state = adrd_pkg::ST_MUX;
      end else if (op != adrd_pkg::C_NONE && op != adrd_pkg::C_CLR) begin
        next_state = adrd_pkg::ST_CONV;
      end
    end else if (run_end) begin
      next_state = adrd_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= a_valid & hwrite;
      wr_addr <= a_ofs;
      hrdata <= (a_valid && !hwrite) ? rd_val : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= 3'd0;
      redundancy_path_select <= 2'b00;
      force_redundancy_fail <= 1'b0;
    end else if (ctrl_wr) begin
      mode <= hwdata[`ADRD_CTRL_MODE_LSB +: 3];
      redundancy_path_select <= hwdata[`ADRD_CTRL_PS_LSB +: 2];
      force_redundancy_fail <= hwdata[`ADRD_CTRL_FF_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= adrd_pkg::ST_IDLE;
      cmd <= adrd_pkg::C_NONE;
      busy <= 1'b0;
      tot_cnt <= 32'h0000_0000;
      step_cnt <= 32'h0000_0000;
      step_idx <= 3'd0;
    end else begin
      state <= next_state;
      busy <= (next_state != adrd_pkg::ST_IDLE);
      cmd <= (state == adrd_pkg::ST_IDLE && op != adrd_pkg::C_NONE) ? op : cmd;
      tot_cnt <= (state == adrd_pkg::ST_IDLE) ? 32'h0000_0000 : tot_cnt + 32'd1;
      step_cnt <= (state == adrd_pkg::ST_IDLE || step_end) ? 32'h0000_0000 : step_cnt + 32'd1;
      step_idx <= (state == adrd_pkg::ST_IDLE) ? 3'd0 : step_idx + 3'(step_end);
    end
  end

  // mux check: any faulty channel seen during the run sets the flag at the end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_fail_flag <= 1'b1;
      mux_acc <= 1'b0;
    end else begin
      mux_acc <= (state == adrd_pkg::ST_MUX) ? (mux_acc | mux_channel_fault) : 1'b0;
      if (op == adrd_pkg::C_CLR) begin
        mux_fail_flag <= 1'b1;
      end else if (state == adrd_pkg::ST_MUX && run_end) begin
        mux_fail_flag <= mux_acc | mux_channel_fault;
      end
    end
  end

  // results: status words cleared to all ones by the clear command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `ADRD_NUM_RES; i++) begin
        res[i] <= `ADRD_RES_RST;
      end
    end else if (op == adrd_pkg::C_CLR) begin
      for (int i = 0; i < 4; i++) begin
        res[`ADRD_IDX_SUM + i] <= `ADRD_RES_RST;
      end
    end else if (step_end) begin
      for (int k = 0; k < 3; k++) begin
        if (wen[k]) begin
          res[widx[k]] <= wval[k];
        end
      end
    end
  end

endmodule // adrd_diag

`default_nettype wire

//--- bench/adrd_props.sv
// Purpose: port assertions for adrd_diag
// Assumes: TIME_DIV matches the bench instance
// Notes: busy bounds span the shortest and longest runs the bench uses
`timescale 1ns/10ps
`default_nettype none
module adrd_props #(
  parameter int unsigned TIME_DIV = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic busy
);
  localparam int unsigned MINB = 384 * 200 / TIME_DIV - 2;
  localparam int unsigned MAXB = 4500 * 200 / TIME_DIV + 2;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int unsigned bcnt;
  logic cmd_dph;
  wire take = hsel && htrans[1] && hready;
  wire cmd_w = take && hwrite && (haddr[7:0] == 8'h04);
  wire rd_res = take && !hwrite && (haddr[7:0] >= 8'h40);
  wire rd_sts = take && !hwrite && (haddr[7:0] == 8'h08);
  // busy run length, sampled at the falling edge of busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt <= 0;
      cmd_dph <= 1'b0;
    end else begin
      bcnt <= busy ? bcnt + 1 : 0;
      cmd_dph <= cmd_w;
    end
  end
  a_busy_start: assert property ($rose(busy) |-> $past(cmd_w, 1) || $past(cmd_w, 2) ||
    $past(cmd_w, 3) || $past(cmd_w, 4)) else $error("busy rose without command");
  a_busy_fall_min: assert property ($fell(busy) |-> bcnt >= MINB)
    else $error("busy ended too soon");
  a_busy_max: assert property (bcnt <= MAXB)
    else $error("busy lasted too long");
  a_fault_lownib: assert property ($past(rd_res) && hrdata[15:4] == 12'hFF0 |->
    hrdata[3:0] != 4'h0) else $error("fault code with empty nibble flags");
  a_result_range: assert property ($past(rd_res) && hrdata[15:0] > 16'hDFFF |->
    hrdata[15:4] inside {12'hFF0, 12'hFFF}) else $error("result out of range");
  a_result_width: assert property ($past(rd_res) |-> hrdata[31:16] == 16'h0000)
    else $error("result wider than 16 bits");
  a_status_busy: assert property ($past(rd_sts) |-> hrdata[0] == busy ||
    hrdata[0] == $past(busy)) else $error("status busy differs from busy");
  a_clear_nobusy: assert property (cmd_dph && hwdata[3:0] == 4'h8 && !busy |->
    ##1 !busy [*3]) else $error("clear started a run");
endmodule // adrd_props
`default_nettype wire

//--- bench/adrd_front.sv
// Purpose: modulator front end feeding adrd_diag
// Assumes: one bit per channel per clock
// Notes: pat has two bits per channel: upper picks random, else lower is the level
`timescale 1ns/10ps
`default_nettype none
module adrd_front (
  input wire logic hclk,
  input wire logic [5:0] pat,
  output logic [2:0] mod_bit
);
  int seed = 62708;
  // a single stream per channel; fanning it to both filters is the design's job
  always @(posedge hclk) begin
    for (int c = 0; c < 3; c++) begin
      mod_bit[c] <= pat[2 * c + 1] ? 1'($random(seed)) : pat[2 * c];
    end
  end
endmodule // adrd_front
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for adrd_diag
// Assumes: TIME_DIV of 100 shortens every run
// Notes: modes kept to 0..2 so the whole run stays short
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int TD = 100;
  localparam logic [3:0] OPS [15] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4,
    4'h5, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6};
  localparam logic [2:0] CFG [15] = '{3'h4, 3'h4, 3'h6, 3'h1, 3'h4, 3'h5, 3'h7,
    3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [19:0] FLT [15] = '{20'h00000, 20'h78000, 20'h00000, 20'h00000,
    20'h00000, 20'h80000, 20'h00000, 20'h09249, 20'h0801F, 20'h003E0, 20'h07C00,
    20'h02040, 20'h00080, 20'h02040, 20'h01000};
  logic hclk, hresetn, hsel, hwrite, ref_up, mux_fault, busy, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize, mod_bit;
  logic [5:0] pat;
  logic [19:0] u;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  int n_fail, check_count, seed, len, mode;
  wire hready = hreadyout;
  adrd_diag #(.TIME_DIV(TD)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mod_bit(mod_bit), .reference_powered_state(ref_up), .mux_channel_fault(mux_fault),
    .busy(busy));
  adrd_front u_front (.hclk(hclk), .pat(pat), .mod_bit(mod_bit));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // polls the busy pin; commands are dropped while it is high
  task automatic run(input logic [3:0] op);
    xfer(1'b1, 8'h04, {28'h0, op});
    len = 0;
    @(negedge hclk);
    for (int i = 0; i < 8 && busy !== 1'b1; i++) @(negedge hclk);
    while (busy === 1'b1) begin
      @(negedge hclk);
      len++;
    end
    @(posedge hclk);
  endtask
  task automatic mux_run(input logic up, input logic bad, input logic [31:0] want);
    ref_up <= up;
    fork
      run(4'h7);
      begin
        repeat (300) @(posedge hclk);
        mux_fault <= bad;
        @(posedge hclk);
        mux_fault <= 1'b0;
      end
    join
    chk({31'h0, near(7, up)}, 32'h1);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, want);
  endtask
  function automatic logic near(input int op, input int m);
    int us [4][3] = '{'{742, 858, 1556}, '{1825, 2116, 3862}, '{1147, 1322, 2369},
      '{384, 442, 791}};
    int t;
    t = (op == 7) ? (m ? 400 : 4500) : us[op < 3 ? 0 : op < 5 ? 1 : op - 3][m];
    t = t * 200 / TD;
    return len >= t - 2 && len <= t + 2;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (95000) @(posedge hclk);
    n_fail++;
    conclude();
  end
  initial begin
    {hresetn, hsel, hwrite, ref_up, mux_fault, htrans, hsize} = 10'h002;
    {haddr, hwdata, n_fail, check_count} = 128'h0;
    seed = 62708;
    pat = 6'h2A;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    xfer(1'b0, 8'h84, 32'h0);
    chk(rd, 32'h0000FFFF);
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    xfer(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed) & 32'h3F;
      xfer(1'b1, 8'h00, v);
      xfer(1'b0, 8'h00, 32'h0);
      chk(rd, v);
    end
    mux_run(1'b1, 1'b0, 32'h0);
    mux_run(1'b0, 1'b1, 32'h2);
    mux_run(1'b1, 1'b0, 32'h0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    for (int k = 0; k < 15; k++) begin
      mode = {$random(seed)} % 3;
      xfer(1'b1, 8'h00, {26'h0, CFG[k], mode[2:0]});
      run(OPS[k]);
      chk({31'h0, near(OPS[k], mode)}, 32'h1);
      u = (OPS[k] < 4'h3) ? 20'h78000 : (OPS[k] < 4'h5) ? 20'h80000 :
        (OPS[k] == 4'h5) ? 20'h0FFFF : 20'h030C0;
      for (int i = 0; i < 20; i++) begin
        if (u[i]) begin
          xfer(1'b0, 8'h40 + 8'(i * 4), 32'h0);
          if (FLT[k][i]) chk(rd, 32'h0000FF01);
          else chk({31'h0, rd <= 32'h0000DFFF}, 32'h1);
        end
      end
    end
    mux_run(1'b1, 1'b0, 32'h0);
    run(4'h8);
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    for (int i = 15; i < 19; i++) begin
      xfer(1'b0, 8'h40 + 8'(i * 4), 32'h0);
      chk(rd, 32'h0000FFFF);
    end
    // ADC1 and ADC3 steady high, ADC2 steady low: slots show which channel landed where
    pat <= 6'h11;
    xfer(1'b1, 8'h00, 32'h0);
    run(4'h6);
    xfer(1'b0, 8'h58, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h74, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 8'h5C, 32'h0);
    v = rd;
    chk({31'h0, v != 32'h0}, 32'h1);
    xfer(1'b0, 8'h70, 32'h0);
    chk(rd, v);
    conclude();
  end
endmodule // testbench
bind adrd_diag adrd_props #(.TIME_DIV(TIME_DIV)) u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .busy(busy));
`default_nettype wire
